// ---- logic/wws_supervisor.sv ----
// Purpose: Rail reset and window watchdog control with Wishbone registers.
// Assumes: Comparator flags and pins are asynchronous and synchronised here.
// Notes: Both outputs are open drain: out is zero, oe pulls the pin low.
`timescale 1ns/1ps
module wws_supervisor #(
	parameter int unsigned RST_FACT_CYCLES = wws_pkg::RST_FACT_CYC,
	parameter int unsigned WD_FACT_CYCLES = wws_pkg::WD_FACT_CYC
) (
	// Clock, reset and enable.
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	// Wishbone slave.
	input wire wws_pkg::wws_wb_req_t wbReq,
	output logic [31:0] wbDatO,
	output logic wbAck,
	// Comparators and pins.
	input wire logic uvFlag,
	input wire logic ovFlag,
	input wire logic kickIn,
	input wire logic cfgSel0,
	input wire logic cfgSel1,
	input wire logic wdTimingPin,
	input wire logic resetTimingPin,
	// Open-drain outputs.
	output logic wdFaultNOut,
	output logic wdFaultNOe,
	output logic railResetNOut,
	output logic railResetNOe,
	// Interrupt.
	output logic irq
);
	import wws_pkg::*;

	logic uvS, ovS, kickS, sel0S, sel1S, wdPinS, rstPinS;
	logic kickPrev, kickFall, inRange, railOk;
	logic [31:0] railCnt, wdCnt, faultCnt, rstDelay, wdUpper, wdLower;
	logic [31:0] wdCap, rstCap;
	logic [IRQ_W-1:0] irqStat, irqMask, irqEvt;
	logic wbHit;
	wws_cfg_t cfg;
	wws_rail_t railState;
	wws_wd_t wdState;

	// Byte-lane merge for writable words.
	function automatic logic [31:0] lanes(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Every pin comes from outside this clock domain.
	wws_sync #(.W(7)) uSync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ce(ce),
		.d({uvFlag, ovFlag, kickIn, cfgSel0, cfgSel1, wdTimingPin,
			resetTimingPin}),
		.q({uvS, ovS, kickS, sel0S, sel1S, wdPinS, rstPinS})
	);

	// Setup decode; pins high select factory timing, low the programmed one.
	always_comb begin
		cfg = wws_decode({sel1S, sel0S}, wdPinS);
		wdUpper = wdPinS ? WD_FACT_CYCLES : wdCap;
		rstDelay = rstPinS ? RST_FACT_CYCLES : rstCap;
		wdLower = wdUpper >> cfg.shift;
	end

	assign inRange = !uvS && !ovS;
	assign railOk = (railState == RAIL_OK);
	assign kickFall = kickPrev && !kickS;

	// Kick edge detector on the synchronised level.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			kickPrev <= 1'b0;
		end else if (ce) begin
			kickPrev <= kickS;
		end
	end

	// Rail state: starts low and waits for the first in-range rail.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			railState <= RAIL_LOW;
			railCnt <= 32'h0;
		end else if (ce) begin
			unique case (railState)
				RAIL_LOW: begin
					railCnt <= 32'h0;
					if (inRange) begin
						railState <= RAIL_COUNT;
					end
				end
				RAIL_COUNT: begin
					railCnt <= railCnt + 32'h1;
					if (!inRange) begin
						railState <= RAIL_LOW;
					end else if (railCnt + 32'h1 >= rstDelay) begin
						railState <= RAIL_OK;
					end
				end
				RAIL_OK: begin
					if (!inRange) begin
						railState <= RAIL_LOW;
					end
				end
			endcase
		end
	end

	// Reset pin pulled low in every state but OK.
	assign railResetNOut = 1'b0;
	assign railResetNOe = !railOk;

	// Watchdog window timing. Leaving disabled or reset restarts from zero.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wdState <= WD_IDLE;
			wdCnt <= 32'h0;
			faultCnt <= 32'h0;
		end else if (ce) begin
			if (!railOk) begin
				wdState <= WD_IDLE;
				wdCnt <= 32'h0;
				faultCnt <= 32'h0;
			end else begin
				unique case (wdState)
					WD_IDLE: begin
						wdCnt <= 32'h0;
						if (!cfg.disabled) begin
							wdState <= WD_RUN;
						end
					end
					WD_RUN: begin
						if (cfg.disabled) begin
							wdState <= WD_IDLE;
						end else if (kickFall && wdCnt < wdLower) begin
							wdState <= WD_FAULT;
							faultCnt <= 32'h0;
						end else if (kickFall) begin
							wdCnt <= 32'h0;
						end else if (wdCnt + 32'h1 >= wdUpper) begin
							wdState <= WD_FAULT;
							faultCnt <= 32'h0;
						end else begin
							wdCnt <= wdCnt + 32'h1;
						end
					end
					WD_FAULT: begin
						// Kicks are ignored for the whole pulse.
						faultCnt <= faultCnt + 32'h1;
						if (faultCnt + 32'h1 >= rstDelay) begin
							wdState <= WD_IDLE;
						end
					end
				endcase
			end
		end
	end

	// Fault pin pulled low only in a pulse while reset is released.
	assign wdFaultNOut = 1'b0;
	assign wdFaultNOe = (wdState == WD_FAULT) && railOk;

	// Events that raise sticky interrupt bits.
	always_comb begin
		irqEvt = '0;
		irqEvt[IRQ_RAIL_BIT] = ce && railOk && !inRange;
		irqEvt[IRQ_REL_BIT] = ce && railState == RAIL_COUNT && inRange &&
			railCnt + 32'h1 >= rstDelay;
		irqEvt[IRQ_WD_BIT] = ce && railOk && wdState == WD_RUN &&
			!cfg.disabled && ((kickFall && wdCnt < wdLower) ||
			(!kickFall && wdCnt + 32'h1 >= wdUpper));
	end

	assign wbHit = wbReq.cyc && wbReq.stb && !wbAck;

	// Wishbone answer one cycle after the strobe; unmapped reads return zero.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wbAck <= 1'b0;
			wbDatO <= 32'h0;
		end else if (ce) begin
			wbAck <= wbHit;
			if (wbHit && !wbReq.we) begin
				unique case (wbReq.adr)
					OFS_STATUS: wbDatO <= {24'h0, 1'b0, wdState,
						railState, railOk, wdFaultNOe, cfg.disabled};
					OFS_IRQ_STAT: wbDatO <= {29'h0, irqStat};
					OFS_IRQ_MASK: wbDatO <= {29'h0, irqMask};
					OFS_WD_CAP: wbDatO <= wdCap;
					OFS_RST_CAP: wbDatO <= rstCap;
					default: wbDatO <= 32'h0;
				endcase
			end
		end
	end

	// Writable setup words. A timeout change takes effect at once.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irqMask <= IRQ_MASK_RST;
			wdCap <= WD_CAP_RST;
			rstCap <= RST_CAP_RST;
		end else if (ce && wbHit && wbReq.we) begin
			if (wbReq.adr == OFS_IRQ_MASK && wbReq.sel[0]) begin
				irqMask <= wbReq.dat[IRQ_W-1:0];
			end
			if (wbReq.adr == OFS_WD_CAP) begin
				wdCap <= lanes(wdCap, wbReq.dat, wbReq.sel);
			end
			if (wbReq.adr == OFS_RST_CAP) begin
				rstCap <= lanes(rstCap, wbReq.dat, wbReq.sel);
			end
		end
	end

	// Sticky status, write one to clear; a new event beats the clear.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irqStat <= '0;
		end else if (ce) begin
			if (wbHit && wbReq.we && wbReq.adr == OFS_IRQ_STAT &&
				wbReq.sel[0]) begin
				irqStat <= (irqStat & ~wbReq.dat[IRQ_W-1:0]) | irqEvt;
			end else begin
				irqStat <= irqStat | irqEvt;
			end
		end
	end

	assign irq = |(irqStat & irqMask);

	// Checks on rail and watchdog behaviour.
	rail_fault_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && !inRange |=> railResetNOe)
		else $error("Reset not asserted on rail fault.");

	release_timer_a: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		$rose(railOk) |-> $past(railState == RAIL_COUNT) &&
			$past(railCnt) + 32'h1 >= $past(rstDelay))
		else $error("Reset released before timer completed.");

	por_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		railState != RAIL_OK |-> railResetNOe && !wdFaultNOe)
		else $error("Reset released while rail not qualified.");

	fault_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		wdFaultNOe |-> !railResetNOe)
		else $error("Fault output driven while reset low.");

	fault_hiz_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && !inRange |=> !wdFaultNOe)
		else $error("Fault output still driven after reset asserted.");

	timeout_fault_a: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		ce && railOk && inRange && wdState == WD_RUN && !cfg.disabled &&
			!kickFall && wdCnt + 32'h1 >= wdUpper |=> wdFaultNOe)
		else $error("Timeout did not raise the fault output.");

	early_kick_a: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		ce && railOk && inRange && wdState == WD_RUN && !cfg.disabled &&
			kickFall && wdCnt < wdLower |=> wdState == WD_FAULT)
		else $error("Early kick not treated as a fault.");

	good_kick_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && railOk && inRange && wdState == WD_RUN && !cfg.disabled &&
			kickFall && wdCnt >= wdLower |=> wdState == WD_RUN && wdCnt == 0)
		else $error("Valid kick did not restart the window.");

	ignore_kick_a: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		ce && (!railOk || (cfg.disabled && wdState != WD_FAULT)) |=>
			wdState != WD_RUN || $past(railOk && wdState == WD_IDLE))
		else $error("Kick timing ran while it should be ignored.");

	pulse_len_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		$fell(wdState == WD_FAULT) && railOk |->
			$past(faultCnt) + 32'h1 >= $past(rstDelay))
		else $error("Fault pulse ended early.");

	// Main scenarios.
	timeout_c: cover property (@(posedge ref_clk) disable iff (!rstn)
		$rose(wdFaultNOe));
	release_c: cover property (@(posedge ref_clk) disable iff (!rstn)
		$rose(railOk));
	kick_c: cover property (@(posedge ref_clk) disable iff (!rstn)
		railOk && wdState == WD_RUN && kickFall && wdCnt >= wdLower);
	irq_c: cover property (@(posedge ref_clk) disable iff (!rstn)
		$rose(irq));
endmodule

// ---- include/wws_pkg.sv ----
// Purpose: Shared constants and types of the window watchdog supervisor.
// Assumes: 40 MHz ref_clk; comparator results arrive as logic levels.
// Notes: Long counts are handed to the top module as parameters.
// How it works
// - Select pins and watchdog timing pin choose ratio, timeout and disable.
// - A falling kick edge inside the window keeps the fault output released.
// - Kick activity is ignored when disabled, in reset or during a fault.
// - A timeout drives the fault output low for the reset delay.
// - The fault output is driven low only while the reset output is high.
// - While the reset output is low the fault output is not driven.
// - The reset output is low while the under or over voltage flag is set.
// - Reset releases after the timer completes; a new fault restarts it.
// - After power-on reset, reset stays low until the rail is first in range.
// - Timing pin high selects factory timeout, low the programmed timeout.
package wws_pkg;

	// Clock rate and the derived cycle count of one millisecond.
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

	// Factory reset delay with the reset timing pin open.
	localparam int unsigned RST_FACT_MS = 200;
	localparam int unsigned RST_FACT_CYC = RST_FACT_MS * CYC_PER_MS;

	// Factory upper watchdog boundary.
	localparam int unsigned WD_FACT_MS = 1600;
	localparam int unsigned WD_FACT_CYC = WD_FACT_MS * CYC_PER_MS;

	// Least spacing the host keeps between select pin changes.
	localparam int unsigned SEL_GAP_US = 550;

	// Register byte offsets.
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
	localparam logic [7:0] OFS_WD_CAP = 8'h0C;
	localparam logic [7:0] OFS_RST_CAP = 8'h10;

	// Interrupt bit positions and width.
	localparam int IRQ_W = 3;
	localparam int IRQ_RAIL_BIT = 0;
	localparam int IRQ_REL_BIT = 1;
	localparam int IRQ_WD_BIT = 2;

	// Values after reset.
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	localparam logic [31:0] WD_CAP_RST = 32'h0010_0000;
	localparam logic [31:0] RST_CAP_RST = 32'h0001_0000;

	// Window ratio as a right shift of the upper boundary.
	localparam logic [1:0] SHIFT_SEL00 = 2'h3;
	localparam logic [1:0] SHIFT_SEL01 = 2'h1;
	localparam logic [1:0] SHIFT_SEL10 = 2'h2;
	localparam logic [1:0] SHIFT_SEL11 = 2'h2;
	localparam logic [1:0] SEL_DISABLE = 2'h3;

	// Decoded watchdog setup.
	typedef struct packed {
		logic disabled;
		logic [1:0] shift;
	} wws_cfg_t;

	// Classic Wishbone request from the master.
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wws_wb_req_t;

	typedef enum logic [1:0] {RAIL_LOW, RAIL_COUNT, RAIL_OK} wws_rail_t;
	typedef enum logic [1:0] {WD_IDLE, WD_RUN, WD_FAULT} wws_wd_t;

	// Select code 11 disables only with the factory timing; with a
	// programmed timeout it gives a quarter ratio instead.
	function automatic wws_cfg_t wws_decode(input logic [1:0] sel,
		input logic factory);
		wws_cfg_t c;
		c.disabled = factory && (sel == SEL_DISABLE);
		unique case (sel)
			2'h0: c.shift = SHIFT_SEL00;
			2'h1: c.shift = SHIFT_SEL01;
			2'h2: c.shift = SHIFT_SEL10;
			2'h3: c.shift = SHIFT_SEL11;
		endcase
		return c;
	endfunction

endpackage

// ---- logic/wws_sync.sv ----
// Purpose: Two flip-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs are slow levels; no pulse shorter than two cycles.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module wws_sync #(
	parameter int W = 1
) (
	// Clock, reset and enable.
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	// Levels.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// Both stages clear to zero, frozen while ce is low.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta <= '0;
			q <= '0;
		end else if (ce) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ---- bench/wws_host_model.sv ----
// Purpose: Host processor that services the watchdog with falling edges.
// Assumes: gap is the kick period less one, in cycles, and above 20.
// Notes: While kicking is off the line is held high, never left floating.
`timescale 1ns/1ps
module wws_host_model (
	// Clock.
	input wire logic ref_clk,
	// Control from the bench.
	input wire logic kickEn,
	input wire logic [15:0] gap,
	// Kick line.
	output logic kickIn
);
	logic [15:0] cnt;

	// Start in the idle level so the first edge cannot come at time zero.
	initial begin
		kickIn = 1'b1;
		cnt = 16'h0014;
	end

	// Low for 20 cycles after each wrap: one falling edge per period.
	always @(posedge ref_clk) begin
		if (!kickEn) begin
			cnt <= 16'h0014;
			kickIn <= 1'b1;
		end else begin
			cnt <= (cnt == gap) ? 16'h0000 : cnt + 16'h0001;
			kickIn <= (cnt >= 16'h0014);
		end
	end
endmodule

// ---- bench/wws_supervisor_tb_top.sv ----
// Purpose: Self-checking bench of the window watchdog supervisor.
// Assumes: Short factory counts of 200 and 1600 cycles.
// Notes: Pin timings allow a few cycles of synchroniser slack.
`timescale 1ns/1ps
module wws_supervisor_tb_top;
	import wws_pkg::*;
	localparam int RD = 200;
	localparam int WU = 1600;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	wws_wb_req_t wbReq = '0;
	logic [31:0] wbDatO;
	logic [31:0] q;
	logic wbAck, irq, wdFaultNOut, wdFaultNOe, railResetNOut, railResetNOe;
	logic uvFlag = 1'b1;
	logic ovFlag = 1'b0;
	logic cfgSel0 = 1'b0;
	logic cfgSel1 = 1'b0;
	logic wdPin = 1'b1;
	logic rstPin = 1'b1;
	logic kickEn = 1'b0;
	logic [15:0] gap = 16'h0320;
	logic kickIn;
	int fails = 0;
	int cmpCount = 0;
	int n;

	// The host drives the kick line; the bench only steers it.
	wws_host_model HOST (.ref_clk(ref_clk), .kickEn(kickEn), .gap(gap),
		.kickIn(kickIn));

	// Timing pins start high so the short factory counts apply first.
	wws_supervisor #(.RST_FACT_CYCLES(RD), .WD_FACT_CYCLES(WU)) DUT (
		.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1), .wbReq(wbReq),
		.wbDatO(wbDatO), .wbAck(wbAck), .uvFlag(uvFlag), .ovFlag(ovFlag),
		.kickIn(kickIn), .cfgSel0(cfgSel0), .cfgSel1(cfgSel1),
		.wdTimingPin(wdPin), .resetTimingPin(rstPin),
		.wdFaultNOut(wdFaultNOut), .wdFaultNOe(wdFaultNOe),
		.railResetNOut(railResetNOut), .railResetNOe(railResetNOe),
		.irq(irq));

	// Free-running 40 MHz clock.
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic close_out();
		$display("Comparisons %0d mismatches %0d", cmpCount, fails);
		if (fails == 0 && cmpCount > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One classic cycle; the request holds until ack is sampled high.
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (wbAck !== 1'b1 && k < 20);
		q = wbDatO;
		wbReq <= '0;
		@(posedge ref_clk);
		// A missing answer ends the run as a mismatch.
		if (k >= 20) begin
			$display("BAD t=%0t ack %h %h", $time, 1'b0, 1'b1);
			fails++;
			close_out();
		end
	endtask

	// Counts edges until the chosen pin enable reaches v; lim bounds it, must makes reaching lim a failure.
	task automatic wait_oe(input bit rail, input logic v, input int lim,
		input bit must);
		n = 0;
		while ((rail ? railResetNOe : wdFaultNOe) !== v && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		if (must && n >= lim) begin
			fails++;
			$display("BAD t=%0t wait %h %h", $time, rail, v);
			close_out();
		end
	endtask

	initial begin
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (10) @(posedge ref_clk);
		cmp(railResetNOe, 1'b1);
		cmp(wdFaultNOe, 1'b0);
		cmp({railResetNOut, wdFaultNOut}, 2'h0);
		// A short over-voltage in mid-count must restart the reset timer.
		uvFlag <= 1'b0;
		repeat (100) @(posedge ref_clk);
		cmp(railResetNOe, 1'b1);
		ovFlag <= 1'b1;
		repeat (10) @(posedge ref_clk);
		cmp(railResetNOe, 1'b1);
		ovFlag <= 1'b0;
		wait_oe(1'b1, 1'b0, 400, 1'b1);
		cmp(n >= RD && n <= RD + 6, 1'b1);
		kickEn <= 1'b1;
		// Release raises its interrupt bit; W1C clears it.
		wb(1'b1, OFS_IRQ_MASK, 32'h7);
		wb(1'b0, OFS_IRQ_STAT, 32'h0);
		cmp(q, 32'h2);
		cmp(irq, 1'b1);
		wb(1'b1, OFS_IRQ_STAT, 32'h2);
		repeat (2) @(posedge ref_clk);
		cmp(irq, 1'b0);
		// Kicks inside the window keep the fault output released.
		wait_oe(1'b0, 1'b1, 4000, 1'b0);
		cmp(n, 4000);
		// Starved watchdog faults for exactly the reset delay.
		kickEn <= 1'b0;
		wait_oe(1'b0, 1'b1, WU + 10, 1'b1);
		cmp(railResetNOe, 1'b0);
		wait_oe(1'b0, 1'b0, RD + 10, 1'b1);
		cmp(n >= RD - 1 && n <= RD + 1, 1'b1);
		wb(1'b0, OFS_IRQ_STAT, 32'h0);
		cmp(q, 32'h4);
		wb(1'b1, OFS_IRQ_STAT, 32'h4);
		// An early kick after the pulse is itself a fault.
		gap <= 16'h0064;
		kickEn <= 1'b1;
		wait_oe(1'b0, 1'b1, 150, 1'b1);
		// A rail fault in mid-pulse releases the fault output at once.
		ovFlag <= 1'b1;
		kickEn <= 1'b0;
		repeat (5) @(posedge ref_clk);
		cmp(railResetNOe, 1'b1);
		cmp(wdFaultNOe, 1'b0);
		ovFlag <= 1'b0;
		wait_oe(1'b1, 1'b0, 300, 1'b1);
		// Disable with the fault output released; one change only.
		cfgSel0 <= 1'b1;
		cfgSel1 <= 1'b1;
		wait_oe(1'b0, 1'b1, 3000, 1'b0);
		cmp(n, 3000);
		wb(1'b0, OFS_STATUS, 32'h0);
		cmp(q[0], 1'b1);
		// Programmed timing: code 11 now gives a quarter ratio, not disable.
		wb(1'b1, OFS_WD_CAP, 32'h0000_03E8);
		wb(1'b1, OFS_RST_CAP, 32'h0000_0064);
		wb(1'b0, OFS_WD_CAP, 32'h0);
		cmp(q, 32'h0000_03E8);
		wdPin <= 1'b0;
		rstPin <= 1'b0;
		wait_oe(1'b0, 1'b1, 1100, 1'b1);
		cmp(n >= 995 && n <= 1010, 1'b1);
		wait_oe(1'b0, 1'b0, 150, 1'b1);
		cmp(n >= 99 && n <= 101, 1'b1);
		wb(1'b0, 8'h40, 32'h0);
		cmp(q, 32'h0);
		close_out();
	end
endmodule
